/* design/flash_ctl_pkg.sv */
package flash_ctl_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  // Register indices as printed; byte address is four times the index
  localparam logic [31:0] IDX_CTRL_LOW = 32'hFFFF8580;
  localparam logic [31:0] IDX_CTRL_HIGH = 32'hFFFF8581;
  localparam logic [31:0] IDX_EBLK_A = 32'hFFFF8582;
  localparam logic [31:0] IDX_EBLK_B = 32'hFFFF8583;
  localparam logic [31:0] IDX_OVERLAY = 32'hFFFF8628;
  localparam logic [ADDR_W-1:0] A_CTRL_LOW = ADDR_W'(IDX_CTRL_LOW << 2);
  localparam logic [ADDR_W-1:0] A_CTRL_HIGH = ADDR_W'(IDX_CTRL_HIGH << 2);
  localparam logic [ADDR_W-1:0] A_EBLK_A = ADDR_W'(IDX_EBLK_A << 2);
  localparam logic [ADDR_W-1:0] A_EBLK_B = ADDR_W'(IDX_EBLK_B << 2);
  localparam logic [ADDR_W-1:0] A_OVERLAY = ADDR_W'(IDX_OVERLAY << 2);

  // Field layout of the control registers
  localparam int MODE_W = 6;
  localparam int HWE_BIT = 7;
  localparam int SWE_BIT = 6;
  localparam int ERR_BIT = 7;
  localparam int ESU_BIT = 5;
  localparam int PSU_BIT = 4;
  localparam int EV_BIT = 3;
  localparam int PV_BIT = 2;
  localparam int GO_E_BIT = 1;
  localparam int GO_P_BIT = 0;
  localparam int EBLK_A_W = 4;
  localparam int EBLK_B_W = 8;
  localparam int EBLK_W = EBLK_A_W + EBLK_B_W;
  localparam int OVL_W = 16;

  // Read values and reset values
  localparam logic [7:0] CTRL_LOW_OFF = 8'h80;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [MODE_W-1:0] MODE_RST = 6'h00;
  localparam logic [EBLK_W-1:0] EBLK_RST = 12'h000;
  localparam logic [OVL_W-1:0] OVL_RST = 16'h0000;

  // Byte lane patterns
  localparam logic [STRB_W-1:0] STRB_BYTE = 4'h1;
  localparam logic [STRB_W-1:0] STRB_LONG = 4'hF;

  // Access cost in clock cycles
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] ACC_CYC = 3'h3;
  localparam logic [CNT_W-1:0] LONG_CYC = 3'h6;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    idle,
    wr_take,
    rd_take,
    wr_acc,
    rd_acc,
    wr_resp,
    rd_resp
  } bus_state_e;

endpackage

/* design/mode_ctl_if.sv */
`timescale 1ns/10ps
interface mode_ctl_if;
  import flash_ctl_pkg::*;
  logic wr;
  logic [MODE_W-1:0] wdata;
  logic gate;
  logic block_erase;
  logic clear;
  logic [MODE_W-1:0] bits;
  modport core (
    input wr, wdata, gate, block_erase, clear,
    output bits
  );
  modport ctrl (
    output wr, wdata, gate, block_erase, clear,
    input bits
  );
endinterface

/* design/mode_bits.sv */
`timescale 1ns/10ps
module mode_bits
  import flash_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control from the register decode
  mode_ctl_if.core io
);

  logic [MODE_W-1:0] next_bits;
  logic esu_ok;
  logic go_e_ok;
  logic go_p_ok;

  // Write qualifiers for the staged bits
  assign esu_ok = io.gate & ~io.block_erase;
  assign go_e_ok = esu_ok & io.bits[ESU_BIT];
  assign go_p_ok = io.gate & io.bits[PSU_BIT];

  // Next value of the six mode bits
  always_comb begin
    next_bits = io.bits;
    if (io.clear) begin
      next_bits = MODE_RST;
    end else if (io.wr) begin
      if (esu_ok) begin
        next_bits[ESU_BIT] = io.wdata[ESU_BIT];
      end
      if (io.gate) begin
        next_bits[PSU_BIT] = io.wdata[PSU_BIT];
        next_bits[EV_BIT] = io.wdata[EV_BIT];
        next_bits[PV_BIT] = io.wdata[PV_BIT];
      end
      if (go_e_ok) begin
        next_bits[GO_E_BIT] = io.wdata[GO_E_BIT];
      end
      if (go_p_ok) begin
        next_bits[GO_P_BIT] = io.wdata[GO_P_BIT];
      end
    end
  end

  // Mode bit storage; a zero releases its mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io.bits <= MODE_RST;
    end else begin
      io.bits <= next_bits;
    end
  end

endmodule

/* design/flash_program_erase_control.sv */
// Contract
// - Byte-only control access, three or six cycles
// - Flash off: high, erase regs read zero
// - Flash off: low control reads 0x80, fixed
// - Low control initial 0x80 pin low, else 0
// - Standby or power-on reset reinitialises low control
// - High, erase regs clear when protected
// - Bit 7 mirrors inverted write-protect pin
// - Software enable settable only with hardware enable
// - Setup and verify writes need both enables
// - Erase go needs enables plus erase setup
// - Program go needs enables plus program setup
// - Clearing a bit releases its mode
// - Upper half uses same sequence and gating
// - Error flag read-only, cleared by reset only
// - Several erase blocks selected: erase bits frozen
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module flash_program_erase_control
  import flash_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Chip state
  input wire logic write_protect_pin,
  input wire logic flash_disabled,
  input wire logic standby,
  input wire logic error_event,
  // Flash array control
  output logic [MODE_W-1:0] low_mode,
  output logic [MODE_W-1:0] high_mode,
  output logic [EBLK_W-1:0] erase_blocks,
  output logic [OVL_W-1:0] ram_overlay_control,
  output logic error_protect,
  output logic array_read_normal
);

  bus_state_e state;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [STRB_W-1:0] wstrb_q;
  logic got_aw;
  logic got_w;
  logic [CNT_W-1:0] cnt;
  logic wp_meta;
  logic wp_sync;
  logic software_write_enable;
  logic flash_error_flag;
  logic [EBLK_A_W-1:0] erase_block_select_a;
  logic [EBLK_B_W-1:0] erase_block_select_b;

  mode_ctl_if low_if ();
  mode_ctl_if high_if ();

  // Write address and data merge, taken in either order
  logic take_aw;
  logic take_w;
  logic aw_done;
  logic w_done;
  logic [ADDR_W-1:0] wr_addr;
  logic [STRB_W-1:0] wr_strb;
  logic [CNT_W-1:0] wr_cost;
  assign take_aw = awvalid & awready;
  assign take_w = wvalid & wready;
  assign aw_done = got_aw | take_aw;
  assign w_done = got_w | take_w;
  assign wr_addr = got_aw ? addr_q : awaddr;
  assign wr_strb = got_w ? wstrb_q : wstrb;
  assign wr_cost = (wr_addr == A_OVERLAY && wr_strb == STRB_LONG) ?
                   LONG_CYC : ACC_CYC;

  // Access strobes at the end of the wait
  logic cnt_end;
  logic wr_stb;
  logic rd_stb;
  assign cnt_end = (cnt == CNT_ZERO);
  assign wr_stb = (state == wr_acc) & cnt_end;
  assign rd_stb = (state == rd_acc) & cnt_end;

  // Address decode
  logic hit_low;
  logic hit_high;
  logic hit_eba;
  logic hit_ebb;
  logic hit_ovl;
  logic hit_byte_reg;
  assign hit_low = (addr_q == A_CTRL_LOW);
  assign hit_high = (addr_q == A_CTRL_HIGH);
  assign hit_eba = (addr_q == A_EBLK_A);
  assign hit_ebb = (addr_q == A_EBLK_B);
  assign hit_ovl = (addr_q == A_OVERLAY);
  assign hit_byte_reg = hit_low | hit_high | hit_eba | hit_ebb;

  // Access width checks
  logic byte_ok;
  logic ovl_ok;
  logic wr_err;
  logic rd_err;
  assign byte_ok = (wstrb_q == STRB_BYTE);
  assign ovl_ok = (wstrb_q[3:2] == 2'b00) | (wstrb_q == STRB_LONG);
  assign wr_err = hit_byte_reg ? ~byte_ok : (hit_ovl ? ~ovl_ok : 1'b1);
  assign rd_err = ~(hit_byte_reg | hit_ovl);

  // Write enables per register; byte registers dead while flash is off, overlay still writable
  logic wr_ok;
  logic wr_low;
  logic wr_high;
  logic wr_eba;
  logic wr_ebb;
  logic wr_ovl;
  assign wr_ok = wr_stb & byte_ok & ~flash_disabled;
  assign wr_low = wr_ok & hit_low;
  assign wr_high = wr_ok & hit_high;
  assign wr_eba = wr_ok & hit_eba;
  assign wr_ebb = wr_ok & hit_ebb;
  assign wr_ovl = wr_stb & hit_ovl & ovl_ok;

  // Protection state
  logic hw_write_enable_status;
  logic both_enable;
  logic prot_clear;
  assign hw_write_enable_status = ~wp_sync;
  assign both_enable = hw_write_enable_status & software_write_enable;
  assign prot_clear = standby | ~both_enable;

  // More than one erase block chosen across both selectors
  logic [EBLK_W-1:0] blk_sel;
  logic multi_blk;
  assign blk_sel = {erase_block_select_b, erase_block_select_a};
  assign multi_blk = |(blk_sel & (blk_sel - EBLK_W'(1)));

  // Mode bit cores for both address halves
  assign low_if.wr = wr_low;
  assign low_if.wdata = wdata_q[MODE_W-1:0];
  assign low_if.gate = both_enable & ~flash_error_flag;
  assign low_if.block_erase = multi_blk;
  assign low_if.clear = standby;
  assign high_if.wr = wr_high;
  assign high_if.wdata = wdata_q[MODE_W-1:0];
  assign high_if.gate = both_enable & ~flash_error_flag;
  assign high_if.block_erase = multi_blk;
  assign high_if.clear = prot_clear;

  mode_bits low_core (
    .clk(clk),
    .rst_n(rst_n),
    .io(low_if.core)
  );

  mode_bits high_core (
    .clk(clk),
    .rst_n(rst_n),
    .io(high_if.core)
  );

  // Readback images of the byte registers
  logic [7:0] low_img;
  logic [7:0] high_img;
  logic [7:0] eba_img;
  logic [7:0] ebb_img;
  logic [DATA_W-1:0] rd_mux;
  assign low_img = flash_disabled ? CTRL_LOW_OFF :
                   {hw_write_enable_status, software_write_enable,
                    low_if.bits};
  assign high_img = flash_disabled ? BYTE_ZERO :
                    {flash_error_flag, 1'b0, high_if.bits};
  assign eba_img = flash_disabled ? BYTE_ZERO :
                   {4'h0, erase_block_select_a};
  assign ebb_img = flash_disabled ? BYTE_ZERO : erase_block_select_b;

  // Read selection
  always_comb begin
    rd_mux = '0;
    if (hit_low) begin
      rd_mux = {24'h000000, low_img};
    end else if (hit_high) begin
      rd_mux = {24'h000000, high_img};
    end else if (hit_eba) begin
      rd_mux = {24'h000000, eba_img};
    end else if (hit_ebb) begin
      rd_mux = {24'h000000, ebb_img};
    end else if (hit_ovl) begin
      rd_mux = {16'h0000, ram_overlay_control};
    end
  end

  // Two-flop synchroniser for the write-protect pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_meta <= 1'b0;
      wp_sync <= 1'b0;
    end else begin
      wp_meta <= write_protect_pin;
      wp_sync <= wp_meta;
    end
  end

  // Software enable, settable only under hardware enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      software_write_enable <= 1'b0;
    end else if (standby) begin
      software_write_enable <= 1'b0;
    end else if (wr_low && hw_write_enable_status) begin
      software_write_enable <= wdata_q[SWE_BIT];
    end
  end

  // Sticky error flag; only power-on reset clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_error_flag <= 1'b0;
    end else if (error_event) begin
      flash_error_flag <= 1'b1;
    end
  end

  // Erase block selectors
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_block_select_a <= EBLK_RST[EBLK_A_W-1:0];
      erase_block_select_b <= EBLK_RST[EBLK_W-1:EBLK_A_W];
    end else if (prot_clear) begin
      erase_block_select_a <= EBLK_RST[EBLK_A_W-1:0];
      erase_block_select_b <= EBLK_RST[EBLK_W-1:EBLK_A_W];
    end else begin
      if (wr_eba) begin
        erase_block_select_a <= wdata_q[EBLK_A_W-1:0];
      end
      if (wr_ebb) begin
        erase_block_select_b <= wdata_q[EBLK_B_W-1:0];
      end
    end
  end

  // RAM overlay register, byte lanes 0 and 1; upper word dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_overlay_control <= OVL_RST;
    end else if (wr_ovl) begin
      if (wstrb_q[0]) begin
        ram_overlay_control[7:0] <= wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
        ram_overlay_control[15:8] <= wdata_q[15:8];
      end
    end
  end

  // Registered array-side outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_mode <= MODE_RST;
      high_mode <= MODE_RST;
      erase_blocks <= EBLK_RST;
      error_protect <= 1'b0;
      array_read_normal <= 1'b1;
    end else begin
      low_mode <= low_if.bits;
      high_mode <= high_if.bits;
      erase_blocks <= blk_sel;
      error_protect <= flash_error_flag;
      array_read_normal <= ~|{low_if.bits, high_if.bits};
    end
  end

  // Capture of address, data and strobes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (take_aw) begin
        addr_q <= awaddr;
      end else if (arvalid && arready) begin
        addr_q <= araddr;
      end
      if (take_w) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  // Bus slave sequencer: one access at a time, three cycles or six for a long overlay write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= idle;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      got_aw <= 1'b0;
      got_w <= 1'b0;
      cnt <= CNT_ZERO;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= '0;
    end else begin
      case (state)
        idle: begin
          if (awvalid || wvalid) begin
            awready <= 1'b1;
            wready <= 1'b1;
            state <= wr_take;
          end else if (arvalid) begin
            arready <= 1'b1;
            state <= rd_take;
          end
        end
        wr_take: begin
          if (take_aw) begin
            awready <= 1'b0;
            got_aw <= 1'b1;
          end
          if (take_w) begin
            wready <= 1'b0;
            got_w <= 1'b1;
          end
          if (aw_done && w_done) begin
            got_aw <= 1'b0;
            got_w <= 1'b0;
            cnt <= wr_cost - CNT_ONE;
            state <= wr_acc;
          end
        end
        rd_take: begin
          if (arvalid) begin
            arready <= 1'b0;
            cnt <= ACC_CYC - CNT_ONE;
            state <= rd_acc;
          end
        end
        wr_acc: begin
          cnt <= cnt - CNT_ONE;
          if (cnt_end) begin
            bvalid <= 1'b1;
            bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
            state <= wr_resp;
          end
        end
        rd_acc: begin
          cnt <= cnt - CNT_ONE;
          if (rd_stb) begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            state <= rd_resp;
          end
        end
        wr_resp: begin
          if (bready) begin
            bvalid <= 1'b0;
            state <= idle;
          end
        end
        rd_resp: begin
          if (rready) begin
            rvalid <= 1'b0;
            state <= idle;
          end
        end
        default: begin
          state <= idle;
        end
      endcase
    end
  end

endmodule

/* verification/flash_pe_asserts.sv */
`timescale 1ns/10ps
module flash_pe_asserts
  import flash_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [STRB_W-1:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Chip state
  input wire logic write_protect_pin,
  input wire logic flash_disabled,
  input wire logic standby,
  input wire logic error_event,
  // Array control
  input wire logic [MODE_W-1:0] low_mode,
  input wire logic [MODE_W-1:0] high_mode,
  input wire logic [EBLK_W-1:0] erase_blocks,
  input wire logic error_protect,
  input wire logic array_read_normal
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Access cost and holding of answers
  wr_byte_cost_a: assert property (
    awvalid && awready && wvalid && wready && wstrb == STRB_BYTE
    |=> !bvalid [*3] ##1 bvalid) else $error("byte write cost");
  wr_long_cost_a: assert property (
    awvalid && awready && wvalid && wready && wstrb == STRB_LONG
    && awaddr == A_OVERLAY |=> !bvalid [*6] ##1 bvalid)
    else $error("long write cost");
  rd_cost_a: assert property (
    arvalid && arready |=> !rvalid [*3] ##1 rvalid)
    else $error("read cost");
  rd_hold_a: assert property (
    rvalid && rready |=> !rvalid && $stable(rdata))
    else $error("read data not held");
  off_low_read_a: assert property (
    flash_disabled && arvalid && arready && araddr == A_CTRL_LOW
    |-> ##4 rdata == {24'h000000, CTRL_LOW_OFF})
    else $error("disabled low read");
  // Mode gating and clearing
  go_prog_a: assert property (
    $rose(low_mode[GO_P_BIT]) |-> $past(low_mode[PSU_BIT]))
    else $error("program go without setup");
  go_erase_hi_a: assert property (
    $rose(high_mode[GO_E_BIT]) |-> $past(high_mode[ESU_BIT]))
    else $error("high erase go without setup");
  protect_clear_a: assert property (
    write_protect_pin [*4] |=> high_mode == MODE_RST
    && erase_blocks == EBLK_RST) else $error("protect clear");
  standby_clear_a: assert property (
    standby [*2] |=> low_mode == MODE_RST && high_mode == MODE_RST)
    else $error("standby clear");
  err_sticky_a: assert property (
    error_event ##1 1'b1 [*2] |-> error_protect ##1 error_protect)
    else $error("error flag");
  normal_read_a: assert property (
    array_read_normal == (low_mode == MODE_RST && high_mode == MODE_RST))
    else $error("normal read flag");
endmodule

bind flash_program_erase_control flash_pe_asserts u_chk (
  .clk(clk), .rst_n(rst_n),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .write_protect_pin(write_protect_pin), .flash_disabled(flash_disabled),
  .standby(standby), .error_event(error_event),
  .low_mode(low_mode), .high_mode(high_mode), .erase_blocks(erase_blocks),
  .error_protect(error_protect), .array_read_normal(array_read_normal)
);

/* verification/tb_flash_program_erase_control.sv */
`timescale 1ns/10ps
module tb_flash_program_erase_control
  import flash_ctl_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [STRB_W-1:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic write_protect_pin = 1'b0, flash_disabled = 1'b0;
  logic standby = 1'b0, error_event = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic error_protect, array_read_normal;
  logic [1:0] bresp, rresp, resp;
  logic [DATA_W-1:0] rdata, rd_val;
  logic [MODE_W-1:0] low_mode, high_mode;
  logic [EBLK_W-1:0] erase_blocks;
  logic [OVL_W-1:0] ram_overlay_control;
  int err_total = 0;
  int checks_done = 0;
  int lat;
  int i;

  flash_program_erase_control dut (
    .clk(clk), .rst_n(rst_n),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .write_protect_pin(write_protect_pin), .flash_disabled(flash_disabled),
    .standby(standby), .error_event(error_event),
    .low_mode(low_mode), .high_mode(high_mode),
    .erase_blocks(erase_blocks),
    .ram_overlay_control(ram_overlay_control),
    .error_protect(error_protect), .array_read_normal(array_read_normal)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task end_sim;
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      $display("ERROR %s exp %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask

  // Write: address and data offered together, bready held until answer
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [STRB_W-1:0] s = STRB_BYTE);
    bit ad, wd, ok;
    ad = 0;
    wd = 0;
    ok = 0;
    lat = 0;
    // One edge between transfers so no signal is set twice at once
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge clk);
      if (ad && wd) begin
        if (bvalid === 1'b1) begin
          ok = 1;
          resp = bresp;
          bready <= 1'b0;
        end else begin
          lat++;
        end
      end
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    if (!ok) begin
      err_total++;
      end_sim();
    end
  endtask

  // Read and compare against the expected register image
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                      input string name);
    bit ad, ok;
    ad = 0;
    ok = 0;
    lat = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge clk);
      if (ad) begin
        if (rvalid === 1'b1) begin
          ok = 1;
          rd_val = rdata;
          resp = rresp;
          rready <= 1'b0;
        end else begin
          lat++;
        end
      end
      if (!ad && arready === 1'b1) begin
        ad = 1;
        arvalid <= 1'b0;
      end
    end
    if (!ok) begin
      err_total++;
      end_sim();
    end
    chk(name, rd_val, exp);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(A_CTRL_LOW, 32'h80, "low init");
    chk("read cost", lat, ACC_CYC);
    rchk(A_CTRL_HIGH, 32'h00, "high init");
    rchk(A_EBLK_A, 32'h00, "blk a init");
    rchk(A_EBLK_B, 32'h00, "blk b init");
    rchk(A_OVERLAY, 32'h00, "overlay init");
    rchk(12'h000, 32'h00, "unmapped");
    chk("unmapped resp", resp, RESP_SLVERR);
    wr(A_CTRL_LOW, 32'h10);
    rchk(A_CTRL_LOW, 32'h80, "setup no enable");
    wr(A_CTRL_LOW, 32'h40);
    chk("write cost", lat, ACC_CYC);
    rchk(A_CTRL_LOW, 32'hC0, "sw enable");
    wr(A_CTRL_LOW, 32'h41);
    rchk(A_CTRL_LOW, 32'hC0, "go no setup");
    // Each setup and verify bit on its own
    for (i = 2; i < 6; i++) begin
      wr(A_CTRL_LOW, 32'h40 | (32'h1 << i));
      rchk(A_CTRL_LOW, 32'hC0 | (32'h1 << i), "mode bit");
      chk("low mode", low_mode, 6'h01 << i);
      chk("not normal", array_read_normal, 1'b0);
      wr(A_CTRL_LOW, 32'h40);
      rchk(A_CTRL_LOW, 32'hC0, "mode release");
      chk("normal", array_read_normal, 1'b1);
    end
    wr(A_CTRL_LOW, 32'h50);
    wr(A_CTRL_LOW, 32'h51);
    rchk(A_CTRL_LOW, 32'hD1, "program");
    chk("program mode", low_mode, 6'h11);
    wr(A_CTRL_LOW, 32'h40);
    wr(A_EBLK_A, 32'h01);
    rchk(A_EBLK_A, 32'h01, "blk a");
    wr(A_CTRL_LOW, 32'h60);
    wr(A_CTRL_LOW, 32'h62);
    rchk(A_CTRL_LOW, 32'hE2, "erase");
    chk("erase blocks", erase_blocks, 12'h001);
    wr(A_CTRL_LOW, 32'h40);
    // Two blocks selected freeze the erase setup bits
    wr(A_EBLK_B, 32'h01);
    wr(A_CTRL_LOW, 32'h60);
    rchk(A_CTRL_LOW, 32'hC0, "multi low");
    wr(A_CTRL_HIGH, 32'h20);
    rchk(A_CTRL_HIGH, 32'h00, "multi high");
    wr(A_EBLK_B, 32'h00);
    wr(A_CTRL_HIGH, 32'h20);
    wr(A_CTRL_HIGH, 32'h22);
    rchk(A_CTRL_HIGH, 32'h22, "high erase");
    chk("high mode", high_mode, 6'h22);
    wr(A_CTRL_HIGH, 32'hC0);
    rchk(A_CTRL_HIGH, 32'h00, "high ro bits");
    // Strobe rules and overlay cost
    wr(A_CTRL_LOW, 32'h44, STRB_LONG);
    chk("wide resp", resp, RESP_SLVERR);
    rchk(A_CTRL_LOW, 32'hC0, "wide ignored");
    wr(A_OVERLAY, 32'h0000A5C3, STRB_LONG);
    chk("long cost", lat, LONG_CYC);
    rchk(A_OVERLAY, 32'hA5C3, "overlay long");
    chk("overlay port", ram_overlay_control, 16'hA5C3);
    wr(A_OVERLAY, 32'h00001234, 4'h3);
    chk("word cost", lat, ACC_CYC);
    rchk(A_OVERLAY, 32'h1234, "overlay word");
    chk("overlay word port", ram_overlay_control, 16'h1234);
    // Flash disabled
    flash_disabled <= 1'b1;
    rchk(A_CTRL_LOW, 32'h80, "off low");
    rchk(A_EBLK_A, 32'h00, "off blk");
    wr(A_EBLK_A, 32'h00);
    wr(A_CTRL_LOW, 32'h00);
    flash_disabled <= 1'b0;
    rchk(A_CTRL_LOW, 32'hC0, "off low kept");
    rchk(A_EBLK_A, 32'h01, "off blk kept");
    // Hardware protect
    wr(A_CTRL_HIGH, 32'h20);
    write_protect_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(A_CTRL_LOW, 32'h40, "protect low");
    rchk(A_CTRL_HIGH, 32'h00, "protect high");
    rchk(A_EBLK_A, 32'h00, "protect blk");
    standby <= 1'b1;
    repeat (3) @(posedge clk);
    standby <= 1'b0;
    rchk(A_CTRL_LOW, 32'h00, "standby");
    wr(A_CTRL_LOW, 32'h40);
    rchk(A_CTRL_LOW, 32'h00, "enable blocked");
    write_protect_pin <= 1'b0;
    repeat (4) @(posedge clk);
    rchk(A_CTRL_LOW, 32'h80, "pin low");
    wr(A_EBLK_A, 32'h01);
    rchk(A_EBLK_A, 32'h00, "no sw enable");
    // Error flag sticky until reset
    wr(A_CTRL_LOW, 32'h40);
    error_event <= 1'b1;
    @(posedge clk);
    error_event <= 1'b0;
    wr(A_CTRL_HIGH, 32'h20);
    rchk(A_CTRL_HIGH, 32'h80, "error flag");
    chk("error protect", error_protect, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(A_CTRL_HIGH, 32'h00, "error reset");
    chk("protect reset", error_protect, 1'b0);
    end_sim();
  end
endmodule
